// file: bench/slcmx_fabric.sv
`timescale 1ns/100ps
// neighbouring slices: cascade feeds come back one cycle late, a from the pair local output, b from the cascade local output or nb_i
module slcmx_fabric (
   input logic mclk_i,
   input logic pair_loc_i,
   input logic casc_loc_i,
   input logic nb_i,
   input logic loop_i,
   output logic feed_a_o,
   output logic feed_b_o
);
   // registered like a real neighbour, so the loop never turns combinational
   always_ff @(posedge mclk_i) begin
      feed_a_o <= pair_loc_i;
      feed_b_o <= loop_i ? casc_loc_i : nb_i;
   end
endmodule : slcmx_fabric

// file: bench/tb.sv
`timescale 1ns/100ps
module tb;
   logic mclk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [3:0] bli = 4'h0, tli = 4'h0;
   logic bsf = 1'b0, tsf = 1'b0, carry_in = 1'b0, nb = 1'b0, loop = 1'b0;
   logic fa, fb;
   logic [15:0] btr = 16'h0000, ttr = 16'h0000;
   slcmx_pkg::slcmx_chain_sel_t chs = slcmx_pkg::SLCMX_CHAIN_CARRY;
   slcmx_pkg::slcmx_gen_sel_t lg = slcmx_pkg::SLCMX_GEN_IN_ONE, hg = slcmx_pkg::SLCMX_GEN_IN_ONE;
   slcmx_pkg::slcmx_prop_sel_t lp = slcmx_pkg::SLCMX_PROP_LUT, hp = slcmx_pkg::SLCMX_PROP_LUT;
   slcmx_pkg::slcmx_out_sel_t xs = slcmx_pkg::SLCMX_OUT_LUT, ys = slcmx_pkg::SLCMX_OUT_LUT;
   logic bot_lut, top_lut, pair_g, pair_l, casc_g, casc_l, cy_up, lsum, hsum, x_out, y_out;
   logic mfa = 1'b0, mfb = 1'b0, p_pr = 1'b0, p_cs = 1'b0;
   int fails = 0, num_checks = 0, cyc = 0;
   wire [10:0] outs = {bot_lut, top_lut, pair_g, pair_l, casc_g, casc_l, cy_up, lsum, hsum,
                       x_out, y_out};
   ////////////////////////////////////////////////////////////////////////////////
   slcmx_slice u_slcmx_slice (
      .mclk_i(mclk_i), .resetn_i(resetn_i), .bottom_lut_in_i(bli), .top_lut_in_i(tli),
      .bottom_side_feed_i(bsf), .top_side_feed_i(tsf), .cascade_feed_in_a_i(fa),
      .cascade_feed_in_b_i(fb), .carry_from_below_i(carry_in), .cfg_bottom_truth_i(btr),
      .cfg_top_truth_i(ttr), .cfg_chain_start_i(chs), .cfg_low_gen_i(lg), .cfg_high_gen_i(hg),
      .cfg_low_prop_i(lp), .cfg_high_prop_i(hp), .cfg_x_sel_i(xs), .cfg_y_sel_i(ys),
      .bottom_lut_o(bot_lut), .top_lut_o(top_lut), .pair_select_o(pair_g),
      .pair_near_feedback_out_o(pair_l), .cascade_select_o(casc_g),
      .cascade_near_feedback_out_o(casc_l), .carry_to_above_o(cy_up), .low_sum_o(lsum),
      .high_sum_o(hsum), .x_o(x_out), .y_o(y_out));
   slcmx_fabric u_slcmx_fabric (
      .mclk_i(mclk_i), .pair_loc_i(pair_l), .casc_loc_i(casc_l), .nb_i(nb), .loop_i(loop),
      .feed_a_o(fa), .feed_b_o(fb));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #12.5 mclk_i = ~mclk_i;
   end
   // ceiling well above the roughly 340 cycles the scenarios need
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         test_done();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      if (fails == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done
   task automatic chk(string n, logic [10:0] e, logic [10:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   function automatic logic gen(slcmx_pkg::slcmx_gen_sel_t c, logic [3:0] v, logic s);
      case (c)
         slcmx_pkg::SLCMX_GEN_IN_ONE: return v[0];
         slcmx_pkg::SLCMX_GEN_IN_TWO: return v[1];
         slcmx_pkg::SLCMX_GEN_PRODUCT: return v[0] & v[1];
         slcmx_pkg::SLCMX_GEN_SIDE: return s;
         slcmx_pkg::SLCMX_GEN_ONE: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : gen
   // one vector: inputs already set after a falling edge, judged one falling edge later
   task automatic step();
      logic bl, tl, pr, cs, ch, lc, hc, ls, hs, na, nbv;
      bl = btr[bli];
      tl = ttr[tli];
      pr = bsf ? tl : bl;
      cs = tsf ? mfb : mfa;
      ch = (chs == slcmx_pkg::SLCMX_CHAIN_SIDE) ? bsf : carry_in;
      lc = (lp == slcmx_pkg::SLCMX_PROP_ONE || bl) ? ch : gen(lg, bli, bsf);
      hc = (hp == slcmx_pkg::SLCMX_PROP_ONE || tl) ? lc : gen(hg, tli, tsf);
      ls = bl ^ ch;
      hs = tl ^ lc;
      na = p_pr;
      nbv = loop ? p_cs : nb;
      @(posedge mclk_i);
      @(negedge mclk_i);
      chk("bottom_lut", bl, bot_lut);
      chk("top_lut", tl, top_lut);
      chk("pair_general", pr, pair_g);
      chk("pair_local", pr, pair_l);
      chk("cascade_general", cs, casc_g);
      chk("cascade_local", cs, casc_l);
      chk("carry_up", hc, cy_up);
      chk("low_sum", ls, lsum);
      chk("high_sum", hs, hsum);
      chk("x", (xs == slcmx_pkg::SLCMX_OUT_SUM) ? ls : bl, x_out);
      chk("y", (ys == slcmx_pkg::SLCMX_OUT_SUM) ? hs : tl, y_out);
      mfa = na;
      mfb = nbv;
      p_pr = pr;
      p_cs = cs;
   endtask : step
   ////////////////////////////////////////////////////////////////////////////////
   // outputs clear at once and stay clear through the reset, model state restarts
   task automatic t_reset();
      @(negedge mclk_i);
      resetn_i = 1'b0;
      nb = 1'b0;
      #1;
      chk("reset_outputs", 11'h000, outs);
      repeat (8) @(negedge mclk_i);
      chk("reset_outputs", 11'h000, outs);
      resetn_i = 1'b1;
      {mfa, mfb, p_pr, p_cs} = 4'h0;
   endtask : t_reset
   task automatic t_lut();
      btr = 16'ha5c3;
      ttr = 16'h3c96;
      for (int i = 0; i < 16; i++) begin
         bli = i[3:0];
         tli = ~i[3:0];
         bsf = i[0];
         tsf = i[1];
         step();
      end
   endtask : t_lut
   // cascade chain: own local output looped back against a toggling neighbour
   task automatic t_wide();
      for (int i = 0; i < 16; i++) begin
         bsf = i[0];
         tsf = i[1];
         loop = i[2];
         nb = i[3] ^ i[0];
         bli = i[3:0];
         step();
      end
   endtask : t_wide
   // every generate code, including the two unused ones, against each propagate choice
   task automatic t_carry();
      btr = 16'h6996;
      ttr = 16'h0ff0;
      for (int i = 0; i < 256; i++) begin
         lg = slcmx_pkg::slcmx_gen_sel_t'(i[2:0]);
         hg = slcmx_pkg::slcmx_gen_sel_t'(~i[2:0]);
         lp = slcmx_pkg::slcmx_prop_sel_t'(i[3]);
         hp = slcmx_pkg::slcmx_prop_sel_t'(i[4]);
         chs = slcmx_pkg::slcmx_chain_sel_t'(i[5]);
         xs = slcmx_pkg::slcmx_out_sel_t'(i[1]);
         ys = slcmx_pkg::slcmx_out_sel_t'(i[6]);
         carry_in = i[6];
         bsf = i[7];
         tsf = i[0];
         // bottom inputs mixed with the upper bits so a zero table output meets every code
         bli = i[3:0] ^ i[7:4];
         tli = i[7:4];
         step();
      end
   endtask : t_carry
   // two-bit adder: half-sum in each generator, carry generated from input one
   task automatic t_add();
      logic [2:0] sum;
      btr = 16'h6666;
      ttr = 16'h6666;
      lg = slcmx_pkg::SLCMX_GEN_IN_ONE;
      hg = slcmx_pkg::SLCMX_GEN_IN_ONE;
      lp = slcmx_pkg::SLCMX_PROP_LUT;
      hp = slcmx_pkg::SLCMX_PROP_LUT;
      chs = slcmx_pkg::SLCMX_CHAIN_CARRY;
      for (int i = 0; i < 32; i++) begin
         bli = {2'h0, i[2], i[0]};
         tli = {2'h0, i[3], i[1]};
         carry_in = i[4];
         sum = 3'(i[1:0]) + 3'(i[3:2]) + 3'(i[4]);
         step();
         chk("adder", 11'(sum), 11'({cy_up, hsum, lsum}));
      end
   endtask : t_add
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      btr = 16'hffff;
      t_reset();
      t_lut();
      t_wide();
      t_reset();
      t_carry();
      t_add();
      test_done();
   end
endmodule : tb

// file: design/slcmx_lut4.sv
`timescale 1ns/100ps
// function generator: the truth table is static configuration, inputs address one bit
module slcmx_lut4 #(
   parameter int INPUTS = 4
) (
   input logic [(2**INPUTS)-1:0] truth_i,
   input logic [INPUTS-1:0] sel_i,
   output logic fout_o
);

   assign fout_o = truth_i[sel_i]; // [RL1] [RL19]

endmodule : slcmx_lut4

// file: design/slcmx_pkg.sv
// Behaviour
// RL1 - two four-input function generators per slice, each realising any four-input function
// RL2 - each generator output reaches wide muxes, carry logic, slice outputs, storage input
// RL3 - bottom pair mux picks between the two generators, selected by bottom side feed
// RL4 - top cascade mux picks between two cascade feed inputs, selected by top side feed
// RL5 - wide mux passes low input on select 0, high on 1; both outputs equal
// RL6 - local output feeds cascade feedback; general output drives the slice outputs
// RL7 - six, seven, eight input muxes cascade in order from pair mux results
// RL8 - carry enters as carry from below and leaves as carry to above
// RL9 - chain start picks carry from below or bottom side feed, fixed by configuration
// RL10 - low generate picks input one, input two, product, side feed, one or zero
// RL11 - high generate picks input one, input two, product, side feed, one or zero
// RL12 - low carry mux gives chain start on propagate 1, low generate on 0
// RL13 - high carry mux gives low carry on propagate 1, high generate on 0
// RL14 - each propagate select is its generator output or constant one
// RL15 - bottom sum is bottom generator output xor chain start value
// RL16 - top sum is top generator output xor low carry value
// RL17 - each product gate ands its generator's first two inputs into its generate mux
// RL18 - generator half-sum steers carry select; sum gate completes two bits per slice
// RL19 - each generator returns the truth-table bit addressed by its four inputs
package slcmx_pkg;

   localparam int LUT_INPUTS = 4;
   localparam int LUT_DEPTH = 16;
   localparam int HALVES = 2;
   localparam int HALF_BOT = 0;
   localparam int HALF_TOP = 1;
   localparam int IN_ONE = 0;
   localparam int IN_TWO = 1;
   localparam int CASCADE_POSITION = 6;
   localparam logic OUT_RESET = 1'h0;

   typedef enum logic [2:0] {
      SLCMX_GEN_IN_ONE = 3'h0,
      SLCMX_GEN_IN_TWO = 3'h1,
      SLCMX_GEN_PRODUCT = 3'h2,
      SLCMX_GEN_SIDE = 3'h3,
      SLCMX_GEN_ONE = 3'h4,
      SLCMX_GEN_ZERO = 3'h5
   } slcmx_gen_sel_t;

   typedef enum logic {
      SLCMX_CHAIN_CARRY = 1'h0,
      SLCMX_CHAIN_SIDE = 1'h1
   } slcmx_chain_sel_t;

   typedef enum logic {
      SLCMX_PROP_LUT = 1'h0,
      SLCMX_PROP_ONE = 1'h1
   } slcmx_prop_sel_t;

   typedef enum logic {
      SLCMX_OUT_LUT = 1'h0,
      SLCMX_OUT_SUM = 1'h1
   } slcmx_out_sel_t;

endpackage : slcmx_pkg

// file: design/slcmx_slice.sv
`timescale 1ns/100ps
// combinational slice core; every output is retimed once so the top drives from flops
module slcmx_slice #(
   parameter int CASCADE_POSITION = slcmx_pkg::CASCADE_POSITION
) (
   input logic mclk_i,
   input logic resetn_i,
   input logic [slcmx_pkg::LUT_INPUTS-1:0] bottom_lut_in_i,
   input logic [slcmx_pkg::LUT_INPUTS-1:0] top_lut_in_i,
   input logic bottom_side_feed_i,
   input logic top_side_feed_i,
   input logic cascade_feed_in_a_i,
   input logic cascade_feed_in_b_i,
   input logic carry_from_below_i,
   input logic [slcmx_pkg::LUT_DEPTH-1:0] cfg_bottom_truth_i,
   input logic [slcmx_pkg::LUT_DEPTH-1:0] cfg_top_truth_i,
   input slcmx_pkg::slcmx_chain_sel_t cfg_chain_start_i,
   input slcmx_pkg::slcmx_gen_sel_t cfg_low_gen_i,
   input slcmx_pkg::slcmx_gen_sel_t cfg_high_gen_i,
   input slcmx_pkg::slcmx_prop_sel_t cfg_low_prop_i,
   input slcmx_pkg::slcmx_prop_sel_t cfg_high_prop_i,
   input slcmx_pkg::slcmx_out_sel_t cfg_x_sel_i,
   input slcmx_pkg::slcmx_out_sel_t cfg_y_sel_i,
   output logic bottom_lut_o,
   output logic top_lut_o,
   output logic pair_select_o,
   output logic pair_near_feedback_out_o,
   output logic cascade_select_o,
   output logic cascade_near_feedback_out_o,
   output logic carry_to_above_o,
   output logic low_sum_o,
   output logic high_sum_o,
   output logic x_o,
   output logic y_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic wide_mux(input logic sel, input logic lo, input logic hi);
      wide_mux = sel ? hi : lo; // [RL5]
   endfunction : wide_mux

   function automatic logic gen_pick(input slcmx_pkg::slcmx_gen_sel_t sel,
                                     input logic in_one, input logic in_two,
                                     input logic product, input logic side);
      logic r;
      r = 1'h0;
      case (sel)
         slcmx_pkg::SLCMX_GEN_IN_ONE: begin
            r = in_one;
         end
         slcmx_pkg::SLCMX_GEN_IN_TWO: begin
            r = in_two;
         end
         slcmx_pkg::SLCMX_GEN_PRODUCT: begin
            r = product;
         end
         slcmx_pkg::SLCMX_GEN_SIDE: begin
            r = side;
         end
         slcmx_pkg::SLCMX_GEN_ONE: begin
            r = 1'h1;
         end
         slcmx_pkg::SLCMX_GEN_ZERO: begin
            r = 1'h0;
         end
         // unused codes fall back to a quiet zero generate
         default: begin
            r = 1'h0;
         end
      endcase
      gen_pick = r;
   endfunction : gen_pick

   ////////////////////////////////////////////////////////////////////////////////
   // function generators

   logic [slcmx_pkg::LUT_INPUTS-1:0] lut_in [slcmx_pkg::HALVES];
   logic [slcmx_pkg::LUT_DEPTH-1:0] lut_truth [slcmx_pkg::HALVES];
   logic [slcmx_pkg::HALVES-1:0] lut_out;
   logic [slcmx_pkg::HALVES-1:0] product;

   assign lut_in[slcmx_pkg::HALF_BOT] = bottom_lut_in_i;
   assign lut_in[slcmx_pkg::HALF_TOP] = top_lut_in_i;
   assign lut_truth[slcmx_pkg::HALF_BOT] = cfg_bottom_truth_i;
   assign lut_truth[slcmx_pkg::HALF_TOP] = cfg_top_truth_i;

   generate
      for (genvar h = 0; h < slcmx_pkg::HALVES; h++) begin : g_half
         slcmx_lut4 #(
            .INPUTS(slcmx_pkg::LUT_INPUTS)
         ) u_lut (
            .truth_i(lut_truth[h]),
            .sel_i(lut_in[h]),
            .fout_o(lut_out[h])
         ); // [RL1] [RL19]
         // product gate duplicates one partial product outside the table
         assign product[h] = lut_in[h][slcmx_pkg::IN_ONE] & lut_in[h][slcmx_pkg::IN_TWO]; // [RL17]
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // wide multiplexers and carry chain

   logic pair_d;
   logic cascade_d;
   logic chain_start;
   logic low_gen;
   logic high_gen;
   logic low_prop;
   logic high_prop;
   logic low_carry;
   logic high_carry;
   logic low_sum;
   logic high_sum;
   logic x_d;
   logic y_d;

   always_comb begin
      // bottom generator on select 0, top generator on select 1
      pair_d = wide_mux(bottom_side_feed_i, lut_out[slcmx_pkg::HALF_BOT],
                        lut_out[slcmx_pkg::HALF_TOP]); // [RL3] [RL2]
      // cascade inputs come from pair or cascade results, here or in a neighbour
      cascade_d = wide_mux(top_side_feed_i, cascade_feed_in_a_i, cascade_feed_in_b_i); // [RL4] [RL7]
   end

   always_comb begin
      chain_start = (cfg_chain_start_i == slcmx_pkg::SLCMX_CHAIN_SIDE) ?
                    bottom_side_feed_i : carry_from_below_i; // [RL9] [RL8]
      low_gen = gen_pick(cfg_low_gen_i, bottom_lut_in_i[slcmx_pkg::IN_ONE],
                         bottom_lut_in_i[slcmx_pkg::IN_TWO],
                         product[slcmx_pkg::HALF_BOT], bottom_side_feed_i); // [RL10] [RL17]
      high_gen = gen_pick(cfg_high_gen_i, top_lut_in_i[slcmx_pkg::IN_ONE],
                          top_lut_in_i[slcmx_pkg::IN_TWO],
                          product[slcmx_pkg::HALF_TOP], top_side_feed_i); // [RL11] [RL17]
      // half-sum in the table steers the carry mux
      low_prop = (cfg_low_prop_i == slcmx_pkg::SLCMX_PROP_ONE) ?
                 1'h1 : lut_out[slcmx_pkg::HALF_BOT]; // [RL14] [RL18]
      high_prop = (cfg_high_prop_i == slcmx_pkg::SLCMX_PROP_ONE) ?
                  1'h1 : lut_out[slcmx_pkg::HALF_TOP]; // [RL14] [RL18]
      low_carry = low_prop ? chain_start : low_gen; // [RL12]
      high_carry = high_prop ? low_carry : high_gen; // [RL13] [RL8]
      low_sum = lut_out[slcmx_pkg::HALF_BOT] ^ chain_start; // [RL15] [RL18]
      high_sum = lut_out[slcmx_pkg::HALF_TOP] ^ low_carry; // [RL16] [RL18]
      x_d = (cfg_x_sel_i == slcmx_pkg::SLCMX_OUT_SUM) ?
            low_sum : lut_out[slcmx_pkg::HALF_BOT]; // [RL2] [RL15]
      y_d = (cfg_y_sel_i == slcmx_pkg::SLCMX_OUT_SUM) ?
            high_sum : lut_out[slcmx_pkg::HALF_TOP]; // [RL2] [RL16]
   end

   ////////////////////////////////////////////////////////////////////////////////
   // output flops; one cycle of latency is the price of flop-driven outputs

   logic bottom_lut_q;
   logic top_lut_q;
   logic pair_gen_q;
   logic pair_loc_q;
   logic casc_gen_q;
   logic casc_loc_q;
   logic carry_q;
   logic low_sum_q;
   logic high_sum_q;
   logic x_q;
   logic y_q;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bottom_lut_q <= slcmx_pkg::OUT_RESET;
         top_lut_q <= slcmx_pkg::OUT_RESET;
      end else begin
         bottom_lut_q <= lut_out[slcmx_pkg::HALF_BOT]; // [RL2]
         top_lut_q <= lut_out[slcmx_pkg::HALF_TOP]; // [RL2]
      end
   end

   // local and general copies kept as separate flops so each can be routed apart
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pair_gen_q <= slcmx_pkg::OUT_RESET;
         pair_loc_q <= slcmx_pkg::OUT_RESET;
         casc_gen_q <= slcmx_pkg::OUT_RESET;
         casc_loc_q <= slcmx_pkg::OUT_RESET;
      end else begin
         pair_gen_q <= pair_d; // [RL6]
         pair_loc_q <= pair_d; // [RL6]
         casc_gen_q <= cascade_d; // [RL6]
         casc_loc_q <= cascade_d; // [RL6]
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         carry_q <= slcmx_pkg::OUT_RESET;
         low_sum_q <= slcmx_pkg::OUT_RESET;
         high_sum_q <= slcmx_pkg::OUT_RESET;
      end else begin
         carry_q <= high_carry; // [RL13]
         low_sum_q <= low_sum; // [RL15]
         high_sum_q <= high_sum; // [RL16]
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         x_q <= slcmx_pkg::OUT_RESET;
         y_q <= slcmx_pkg::OUT_RESET;
      end else begin
         x_q <= x_d;
         y_q <= y_d;
      end
   end

   assign bottom_lut_o = bottom_lut_q;
   assign top_lut_o = top_lut_q;
   assign pair_select_o = pair_gen_q;
   assign pair_near_feedback_out_o = pair_loc_q;
   assign cascade_select_o = casc_gen_q;
   assign cascade_near_feedback_out_o = casc_loc_q;
   assign carry_to_above_o = carry_q;
   assign low_sum_o = low_sum_q;
   assign high_sum_o = high_sum_q;
   assign x_o = x_q;
   assign y_o = y_q;

   // checks other than a_local_eq wait one edge after reset, until the output flops hold real results
   logic armed_q;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         armed_q <= 1'h0;
      end else begin
         armed_q <= 1'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks against the pins one cycle earlier, except a_local_eq, which compares the outputs alone

   property p_lut_lookup;
      @(posedge mclk_i) disable iff (!resetn_i)
      armed_q |->
      bottom_lut_o == $past(cfg_bottom_truth_i[bottom_lut_in_i]) &&
      top_lut_o == $past(cfg_top_truth_i[top_lut_in_i]);
   endproperty
   a_lut_lookup: assert property (p_lut_lookup) else $error("lut output wrong"); // [RL19]

   property p_pair_sel;
      @(posedge mclk_i) disable iff (!resetn_i)
      armed_q && $past(bottom_side_feed_i) |-> pair_select_o == top_lut_o;
   endproperty
   a_pair_sel: assert property (p_pair_sel) else $error("pair mux high wrong"); // [RL3]

   property p_pair_low;
      @(posedge mclk_i) disable iff (!resetn_i)
      armed_q && !$past(bottom_side_feed_i) |-> pair_select_o == bottom_lut_o;
   endproperty
   a_pair_low: assert property (p_pair_low) else $error("pair mux low wrong"); // [RL5]

   property p_cascade;
      @(posedge mclk_i) disable iff (!resetn_i)
      armed_q |->
      cascade_select_o == ($past(top_side_feed_i) ? $past(cascade_feed_in_b_i)
                                                  : $past(cascade_feed_in_a_i));
   endproperty
   a_cascade: assert property (p_cascade) else $error("cascade mux wrong"); // [RL4]

   property p_local_eq;
      @(posedge mclk_i) disable iff (!resetn_i)
      pair_near_feedback_out_o == pair_select_o &&
      cascade_near_feedback_out_o == cascade_select_o;
   endproperty
   a_local_eq: assert property (p_local_eq) else $error("local and general differ"); // [RL6]

   property p_low_sum;
      @(posedge mclk_i) disable iff (!resetn_i)
      armed_q |->
      low_sum_o == (bottom_lut_o ^ ($past(cfg_chain_start_i) == slcmx_pkg::SLCMX_CHAIN_SIDE ?
                    $past(bottom_side_feed_i) : $past(carry_from_below_i)));
   endproperty
   a_low_sum: assert property (p_low_sum) else $error("bottom sum wrong"); // [RL15]

   property p_prop_all;
      @(posedge mclk_i) disable iff (!resetn_i)
      (armed_q && $past(cfg_low_prop_i) == slcmx_pkg::SLCMX_PROP_ONE &&
       $past(cfg_high_prop_i) == slcmx_pkg::SLCMX_PROP_ONE &&
       $past(cfg_chain_start_i) == slcmx_pkg::SLCMX_CHAIN_CARRY)
      |-> carry_to_above_o == $past(carry_from_below_i);
   endproperty
   a_prop_all: assert property (p_prop_all) else $error("carry not propagated"); // [RL12]

   property p_high_gen;
      @(posedge mclk_i) disable iff (!resetn_i)
      (armed_q && $past(cfg_high_prop_i) == slcmx_pkg::SLCMX_PROP_LUT && !top_lut_o &&
       $past(cfg_high_gen_i) == slcmx_pkg::SLCMX_GEN_PRODUCT)
      |-> carry_to_above_o == ($past(top_lut_in_i[0]) & $past(top_lut_in_i[1]));
   endproperty
   a_high_gen: assert property (p_high_gen) else $error("top generate wrong"); // [RL13]

   property p_low_gen_const;
      @(posedge mclk_i) disable iff (!resetn_i)
      (armed_q && $past(cfg_low_prop_i) == slcmx_pkg::SLCMX_PROP_LUT && !bottom_lut_o &&
       $past(cfg_high_prop_i) == slcmx_pkg::SLCMX_PROP_ONE &&
       $past(cfg_low_gen_i) == slcmx_pkg::SLCMX_GEN_ONE)
      |-> carry_to_above_o && (high_sum_o == !top_lut_o);
   endproperty
   a_low_gen_const: assert property (p_low_gen_const) else $error("low generate wrong"); // [RL10]

   property p_x_sel;
      @(posedge mclk_i) disable iff (!resetn_i)
      armed_q |->
      x_o == ($past(cfg_x_sel_i) == slcmx_pkg::SLCMX_OUT_SUM ? low_sum_o : bottom_lut_o) &&
      y_o == ($past(cfg_y_sel_i) == slcmx_pkg::SLCMX_OUT_SUM ? high_sum_o : top_lut_o);
   endproperty
   a_x_sel: assert property (p_x_sel) else $error("slice output select wrong"); // [RL2]

endmodule : slcmx_slice
